// [stw_defs.vh]
// Constants of the servo tuning and warning parameter bank.
// Assumes inclusion by bare name from the design files of this folder.
`ifndef STW_DEFS_VH
`define STW_DEFS_VH

// ---------------------------------------------------------------
// Register offsets (each is an object index; its byte address would
// be four times the index).
// ---------------------------------------------------------------
`define STW_IDX_AUTOTUNE_CUST  16'h3632
`define STW_IDX_HYB_GAIN       16'h3634
`define STW_IDX_HYB_FILTER     16'h3635
`define STW_IDX_VIB_THRESHOLD  16'h3637
`define STW_IDX_WARN_MASK      16'h3638
`define STW_IDX_PANEL_SELECT   16'h3700
`define STW_IDX_WARN_STATUS    16'h3639
`define STW_IDX_TUNE_EFFECT    16'h363A

// ---------------------------------------------------------------
// Reset values and limits.
// ---------------------------------------------------------------
`define STW_RST_AUTOTUNE_CUST  16'h0000
`define STW_RST_HYB_GAIN       16'h0000
`define STW_RST_HYB_FILTER     16'h000A
`define STW_RST_VIB_THRESHOLD  16'h0000
`define STW_RST_WARN_MASK      16'h0004
`define STW_RST_PANEL_SELECT   16'h0000
`define STW_MAX_HYB_GAIN       16'h7530
`define STW_MAX_HYB_FILTER     16'h1900
`define STW_MAX_VIB_THRESHOLD  16'h03E8
`define STW_MAX_PANEL_SELECT   16'h7FFF
`define STW_LOAD_LIMIT_PCT     8'h55

// ---------------------------------------------------------------
// Autotuning customization field positions.
// ---------------------------------------------------------------
`define STW_AT_LOAD_EST_LSB    0
`define STW_AT_INERTIA_LSB     2
`define STW_AT_TORQUE_LSB      4
`define STW_AT_RIGID_BIT       7
`define STW_AT_FIXED_BIT       8
`define STW_AT_GAINSW_LSB      9

// ---------------------------------------------------------------
// Warning mask bit positions.
// ---------------------------------------------------------------
`define STW_WB_BATTERY         0
`define STW_WB_LIFE            2
`define STW_WB_ENC_HOT         3
`define STW_WB_ENC_COMM        4
`define STW_WB_REGEN           5
`define STW_WB_FAN             6
`define STW_WB_OVERLOAD        7
`define STW_WB_EXT_ERR         8
`define STW_WB_VIBRATION       9
`define STW_WB_EXT_COMM        10

// ---------------------------------------------------------------
// Timing.
// ---------------------------------------------------------------
`define STW_CLK_HZ             50000000
`define STW_FAN_STOP_MS        1000

`endif

// [stw_cfg_reg.v]
// One 16-bit configuration word with write clamping to a legal range.
// Assumes a synchronous active-high reset and the shared system clock.
`timescale 1ns/100ps
`default_nettype none

module stw_cfg_reg #(
  parameter [15:0] RESET_VAL = 16'h0000,
  parameter [15:0] MAX_VAL   = 16'hFFFF
) (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire        wr_i,
  input  wire [15:0] wdata_i,
  output reg  [15:0] value_o
);

  // Values written above the range saturate, so the datapath never sees an illegal setting.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      value_o <= RESET_VAL;
    end else if (wr_i) begin
      value_o <= (wdata_i > MAX_VAL) ? MAX_VAL : wdata_i;
    end
  end

endmodule
`default_nettype wire

// [stw_param_bank.v]
// Servo tuning and warning parameter bank: register file, warning detection and
// the decoded autotuning settings.
// Assumes a bus master that strobes for one cycle and takes read data next cycle.
`timescale 1ns/100ps
`default_nettype none
`include "stw_defs.vh"

module stw_param_bank #(
  parameter integer FAN_STOP_CYCLES = (`STW_CLK_HZ / 1000) * `STW_FAN_STOP_MS,
  parameter [7:0]   ENC_ERR_LIMIT   = 8'h03,
  parameter [7:0]   EXT_ERR_LIMIT   = 8'h03
) (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire [15:0] addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [15:0] rdata_o,
  input  wire        fully_closed_i,
  input  wire [15:0] torque_vib_i,
  input  wire [7:0]  load_ratio_i,
  input  wire [7:0]  regen_ratio_i,
  input  wire        fan_stopped_i,
  input  wire        enc_comm_err_i,
  input  wire        enc_frame_ok_i,
  input  wire        ext_comm_err_i,
  input  wire        ext_frame_ok_i,
  input  wire        ext_enc_warn_i,
  input  wire        enc_overheat_i,
  input  wire        life_low_i,
  input  wire        battery_low_i,
  output reg  [15:0] warn_status_o,
  output reg         warn_any_o,
  output reg  [15:0] hyb_gain_o,
  output reg  [15:0] hyb_filter_o,
  output reg  [14:0] panel_select_o,
  output reg  [1:0]  load_est_o,
  output reg  [1:0]  inertia_upd_o,
  output reg  [2:0]  torque_comp_o,
  output reg         rigid_en_o,
  output reg         fixed_obj_o,
  output reg  [1:0]  gain_switch_o
);

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  function hit;
    input [15:0] a;
    input [15:0] idx;
    begin
      hit = (a == idx);
    end
  endfunction

  wire [15:0] gain_q;
  wire [15:0] filter_q;
  wire [15:0] thresh_q;
  wire [15:0] panel_q;
  reg  [15:0] autotune_q;
  reg  [15:0] mask_q;

  stw_cfg_reg #(.RESET_VAL(`STW_RST_HYB_GAIN), .MAX_VAL(`STW_MAX_HYB_GAIN)) u_gain (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_i && hit(addr_i, `STW_IDX_HYB_GAIN)),
    .wdata_i   (wdata_i),
    .value_o   (gain_q)
  );

  stw_cfg_reg #(.RESET_VAL(`STW_RST_HYB_FILTER), .MAX_VAL(`STW_MAX_HYB_FILTER)) u_filter (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_i && hit(addr_i, `STW_IDX_HYB_FILTER)),
    .wdata_i   (wdata_i),
    .value_o   (filter_q)
  );

  stw_cfg_reg #(.RESET_VAL(`STW_RST_VIB_THRESHOLD), .MAX_VAL(`STW_MAX_VIB_THRESHOLD)) u_thresh (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_i && hit(addr_i, `STW_IDX_VIB_THRESHOLD)),
    .wdata_i   (wdata_i),
    .value_o   (thresh_q)
  );

  stw_cfg_reg #(.RESET_VAL(`STW_RST_PANEL_SELECT), .MAX_VAL(`STW_MAX_PANEL_SELECT)) u_panel (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_i && hit(addr_i, `STW_IDX_PANEL_SELECT)),
    .wdata_i   (wdata_i),
    .value_o   (panel_q)
  );

  // The autotuning word and the mask take any 16-bit pattern unchanged.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      autotune_q <= `STW_RST_AUTOTUNE_CUST;
      mask_q     <= `STW_RST_WARN_MASK;
    end else if (wr_i) begin
      if (hit(addr_i, `STW_IDX_AUTOTUNE_CUST)) begin
        autotune_q <= wdata_i;
      end
      if (hit(addr_i, `STW_IDX_WARN_MASK)) begin
        mask_q <= wdata_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // Condition qualifiers
  // ---------------------------------------------------------------
  // Fan stop timer: the condition must hold without a break for the full second.
  reg  [31:0] fan_cnt_q;
  wire        fan_long = (fan_cnt_q >= FAN_STOP_CYCLES);

  always @(posedge sys_clk_i) begin
    if (rst_i || !fan_stopped_i) begin
      fan_cnt_q <= 32'h0000_0000;
    end else if (!fan_long) begin
      fan_cnt_q <= fan_cnt_q + 32'h0000_0001;
    end
  end

  // Consecutive error counters saturate and restart on any good frame.
  reg [7:0] enc_run_q;
  reg [7:0] ext_run_q;

  function [7:0] run_next;
    input [7:0] cur;
    input       err;
    input       ok;
    begin
      if (ok) begin
        run_next = 8'h00;
      end else if (err && cur != 8'hFF) begin
        run_next = cur + 8'h01;
      end else begin
        run_next = cur;
      end
    end
  endfunction

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      enc_run_q <= 8'h00;
      ext_run_q <= 8'h00;
    end else begin
      enc_run_q <= run_next(enc_run_q, enc_comm_err_i, enc_frame_ok_i);
      ext_run_q <= run_next(ext_run_q, ext_comm_err_i, ext_frame_ok_i);
    end
  end

  // ---------------------------------------------------------------
  // Warning detection
  // ---------------------------------------------------------------
  reg [15:0] raw_warn;

  always @* begin
    raw_warn                    = 16'h0000;
    raw_warn[`STW_WB_VIBRATION] = (torque_vib_i > thresh_q);
    raw_warn[`STW_WB_OVERLOAD]  = (load_ratio_i >= `STW_LOAD_LIMIT_PCT);
    raw_warn[`STW_WB_REGEN]     = (regen_ratio_i >= `STW_LOAD_LIMIT_PCT);
    raw_warn[`STW_WB_FAN]       = fan_long;
    raw_warn[`STW_WB_ENC_COMM]  = (enc_run_q > ENC_ERR_LIMIT);
    raw_warn[`STW_WB_EXT_COMM]  = (ext_run_q > EXT_ERR_LIMIT);
    raw_warn[`STW_WB_EXT_ERR]   = ext_enc_warn_i;
    raw_warn[`STW_WB_ENC_HOT]   = enc_overheat_i;
    raw_warn[`STW_WB_LIFE]      = life_low_i;
    raw_warn[`STW_WB_BATTERY]   = battery_low_i;
  end

  // Gating before the status flop means a newly masked warning stays visible for one more cycle, until the flop reloads.
  wire [15:0] warn_d = raw_warn & ~mask_q;

  // ---------------------------------------------------------------
  // Outputs and read port
  // ---------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      warn_status_o  <= 16'h0000;
      warn_any_o     <= 1'b0;
      hyb_gain_o     <= 16'h0000;
      hyb_filter_o   <= 16'h0000;
      panel_select_o <= 15'h0000;
      load_est_o     <= 2'h0;
      inertia_upd_o  <= 2'h0;
      torque_comp_o  <= 3'h0;
      rigid_en_o     <= 1'b0;
      fixed_obj_o    <= 1'b0;
      gain_switch_o  <= 2'h0;
    end else begin
      warn_status_o  <= warn_d;
      warn_any_o     <= |warn_d;
      // Suppression only acts in fully-closed control; elsewhere the loop sees zero gain.
      hyb_gain_o     <= fully_closed_i ? gain_q : 16'h0000;
      hyb_filter_o   <= filter_q;
      panel_select_o <= panel_q[14:0];
      load_est_o     <= autotune_q[`STW_AT_LOAD_EST_LSB +: 2];
      inertia_upd_o  <= (autotune_q[`STW_AT_LOAD_EST_LSB +: 2] == 2'h0) ? 2'h0
                        : autotune_q[`STW_AT_INERTIA_LSB +: 2];
      torque_comp_o  <= autotune_q[`STW_AT_TORQUE_LSB +: 3];
      rigid_en_o     <= autotune_q[`STW_AT_RIGID_BIT];
      fixed_obj_o    <= autotune_q[`STW_AT_FIXED_BIT];
      gain_switch_o  <= autotune_q[`STW_AT_GAINSW_LSB +: 2];
    end
  end

  // Read data stand for exactly one cycle after the strobe; otherwise zero.
  always @(posedge sys_clk_i) begin
    if (rst_i || !rd_i) begin
      rdata_o <= 16'h0000;
    end else begin
      case (addr_i)
        `STW_IDX_AUTOTUNE_CUST: rdata_o <= autotune_q;
        `STW_IDX_HYB_GAIN:      rdata_o <= gain_q;
        `STW_IDX_HYB_FILTER:    rdata_o <= filter_q;
        `STW_IDX_VIB_THRESHOLD: rdata_o <= thresh_q;
        `STW_IDX_WARN_MASK:     rdata_o <= mask_q;
        `STW_IDX_PANEL_SELECT:  rdata_o <= panel_q;
        `STW_IDX_WARN_STATUS:   rdata_o <= warn_status_o;
        `STW_IDX_TUNE_EFFECT:   rdata_o <= {5'h00, gain_switch_o, fixed_obj_o, rigid_en_o,
                                            torque_comp_o, inertia_upd_o, load_est_o};
        default:                rdata_o <= 16'h0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// [stw_param_bank_properties.sv]
// Port-level checks of the parameter bank, bound onto its top module.
// Assumes single clock, synchronous reset; mask is shadowed from bus writes.
`timescale 1ns/100ps
`default_nettype none
module stw_param_bank_properties #(
  parameter integer FAN_STOP_CYCLES = 20
) (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic [7:0]  load_ratio_i,
  input wire logic [7:0]  regen_ratio_i,
  input wire logic        fan_stopped_i,
  input wire logic        battery_low_i,
  input wire logic [15:0] warn_status_o,
  input wire logic [1:0]  load_est_o,
  input wire logic [1:0]  inertia_upd_o
);
  logic [15:0] mask_q;
  logic [31:0] fan_q;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Saturating run length of stopped-fan samples.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      mask_q <= 16'h0004;
      fan_q  <= 32'h0000_0000;
    end else begin
      if (wr_i && addr_i == 16'h3638)
        mask_q <= wdata_i;
      fan_q <= !fan_stopped_i ? 32'h0000_0000 : fan_q + {31'h0000_0000, fan_q != 32'hFFFF_FFFF};
    end
  end
  sequence s_fan_held;
    (fan_q > FAN_STOP_CYCLES && !mask_q[6]) [*2];
  endsequence
  property p_batt;
    battery_low_i && !mask_q[0] |=> warn_status_o[0];
  endproperty
  a_batt: assert property (p_batt) else $error("battery warning missing");
  property p_ovl;
    1'b1 |=> warn_status_o[7] == $past(load_ratio_i >= 8'h55 && !mask_q[7]);
  endproperty
  a_ovl: assert property (p_ovl) else $error("overload warning wrong");
  property p_regen;
    1'b1 |=> warn_status_o[5] == $past(regen_ratio_i >= 8'h55 && !mask_q[5]);
  endproperty
  a_regen: assert property (p_regen) else $error("regeneration warning wrong");
  property p_mask;
    1'b1 |=> (warn_status_o & $past(mask_q)) == 16'h0000;
  endproperty
  a_mask: assert property (p_mask) else $error("masked warning seen");
  property p_mask_rd;
    rd_i && addr_i == 16'h3638 |=> rdata_o == $past(mask_q);
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask read wrong");
  property p_inertia;
    load_est_o == 2'b00 |-> inertia_upd_o == 2'b00;
  endproperty
  a_inertia: assert property (p_inertia) else $error("inertia update not forced off");
  property p_fan_early;
    warn_status_o[6] |-> $past(fan_q) >= FAN_STOP_CYCLES;
  endproperty
  a_fan_early: assert property (p_fan_early) else $error("fan warning too early");
  property p_fan_late;
    s_fan_held |-> warn_status_o[6];
  endproperty
  a_fan_late: assert property (p_fan_late) else $error("fan warning missing");
endmodule
bind stw_param_bank stw_param_bank_properties #(.FAN_STOP_CYCLES(FAN_STOP_CYCLES)) u_props (
  .sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .load_ratio_i, .regen_ratio_i,
  .fan_stopped_i, .battery_low_i, .warn_status_o, .load_est_o, .inertia_upd_o);
`default_nettype wire

// [stw_param_bank_tb.sv]
// Self-checking bench: register table, packed autotune word and warnings.
// Assumes the design and checker files of this folder are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("BAD %0t %h vs %h", $time, g, e); end end
module stw_param_bank_tb;
  localparam integer FAN = 20;
  logic        sys_clk_i, rst_i, wr_i, rd_i, fully_closed_i, fan_stopped_i, warn_any_o, rigid_en_o, fixed_obj_o;
  logic        enc_comm_err_i, enc_frame_ok_i, ext_comm_err_i, ext_frame_ok_i;
  logic        ext_enc_warn_i, enc_overheat_i, life_low_i, battery_low_i;
  logic [15:0] addr_i, wdata_i, torque_vib_i, rdata_o, warn_status_o, hyb_gain_o, hyb_filter_o, q, v, e, thr;
  logic [14:0] panel_select_o;
  logic [7:0]  load_ratio_i, regen_ratio_i;
  logic [2:0]  torque_comp_o;
  logic [1:0]  load_est_o, inertia_upd_o, gain_switch_o;
  int          n_errors, n_checks, cyc, l, i, t, g;
  int unsigned seed;
  logic [15:0] ra[5] = '{16'h3634, 16'h3635, 16'h3637, 16'h3638, 16'h3700};
  logic [15:0] rv[5] = '{16'h0000, 16'h000A, 16'h0000, 16'h0004, 16'h0000};
  logic [15:0] mx[5] = '{16'h7530, 16'h1900, 16'h03E8, 16'hFFFF, 16'h7FFF};
  int          wb[8] = '{0, 2, 3, 5, 6, 7, 8, 9};
  stw_param_bank #(.FAN_STOP_CYCLES(FAN)) u_stw_param_bank (
    .sys_clk_i      (sys_clk_i),
    .rst_i          (rst_i),
    .addr_i         (addr_i),
    .wdata_i        (wdata_i),
    .wr_i           (wr_i),
    .rd_i           (rd_i),
    .rdata_o        (rdata_o),
    .fully_closed_i (fully_closed_i),
    .torque_vib_i   (torque_vib_i),
    .load_ratio_i   (load_ratio_i),
    .regen_ratio_i  (regen_ratio_i),
    .fan_stopped_i  (fan_stopped_i),
    .enc_comm_err_i (enc_comm_err_i),
    .enc_frame_ok_i (enc_frame_ok_i),
    .ext_comm_err_i (ext_comm_err_i),
    .ext_frame_ok_i (ext_frame_ok_i),
    .ext_enc_warn_i (ext_enc_warn_i),
    .enc_overheat_i (enc_overheat_i),
    .life_low_i     (life_low_i),
    .battery_low_i  (battery_low_i),
    .warn_status_o  (warn_status_o),
    .warn_any_o     (warn_any_o),
    .hyb_gain_o     (hyb_gain_o),
    .hyb_filter_o   (hyb_filter_o),
    .panel_select_o (panel_select_o),
    .load_est_o     (load_est_o),
    .inertia_upd_o  (inertia_upd_o),
    .torque_comp_o  (torque_comp_o),
    .rigid_en_o     (rigid_en_o),
    .fixed_obj_o    (fixed_obj_o),
    .gain_switch_o  (gain_switch_o)
  );
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  function automatic logic [15:0] sat(input logic [15:0] x, m);
    return x > m ? m : x;
  endfunction
  function automatic logic [15:0] pack(input int l, i, t, r, f, g);
    return 16'(l * 1 + i * 4 + t * 16 + r * 128 + f * 256 + g * 512);
  endfunction
  task automatic wr(input logic [15:0] a, d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    q = rdata_o;
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  // Drives each condition to just on or just below its trip point.
  task automatic cond(input int b, input logic on);
    @(posedge sys_clk_i);
    case (b)
      0: battery_low_i <= on;
      2: life_low_i <= on;
      3: enc_overheat_i <= on;
      5: regen_ratio_i <= on ? 8'h55 : 8'h54;
      7: load_ratio_i <= on ? 8'h55 : 8'h54;
      8: ext_enc_warn_i <= on;
      9: torque_vib_i <= thr + {15'h0000, on};
      default: fan_stopped_i <= on;
    endcase
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    {wr_i, rd_i, fully_closed_i, fan_stopped_i, enc_comm_err_i, enc_frame_ok_i, ext_comm_err_i} = '0;
    {ext_frame_ok_i, ext_enc_warn_i, enc_overheat_i, life_low_i, battery_low_i} = '0;
    {addr_i, wdata_i, torque_vib_i, load_ratio_i, regen_ratio_i} = '0;
    rst_i = 1'b1;
    seed = $urandom(70);
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    foreach (ra[k]) begin rd(ra[k]); `CHK(q, rv[k]) end
    rd(16'h3636); `CHK(q, 16'h0000)
    // Software starts the suppression gain at the position loop gain, here 48.0 per second.
    wr(16'h3634, 16'h01E0);
    rd(16'h3634);
    `CHK(q, 16'h01E0)
    // Limits, saturation above them and the gain gating by control mode.
    foreach (ra[k]) for (int j = 0; j < 4; j++) begin
      v = j == 0 ? mx[k] : j == 1 ? mx[k] + 16'h0001 : 16'($urandom);
      e = sat(v, mx[k]);
      @(posedge sys_clk_i);
      fully_closed_i <= 1'($urandom);
      wr(ra[k], v);
      rd(ra[k]); `CHK(q, e)
      if (k == 0) `CHK(hyb_gain_o, fully_closed_i ? e : 16'h0000)
      if (k == 1) `CHK(hyb_filter_o, e)
      if (k == 4) `CHK(panel_select_o, e[14:0])
    end
    // Packed autotune word, first the worked example then random fields.
    for (int n = 0; n < 12; n++) begin
      {l, i, t, g} = n == 0 ? {32'd1, 32'd1, 32'd3, 32'd2} : {$urandom % 4, $urandom % 4, $urandom % 8, $urandom % 4};
      v = pack(l, i, t, n == 0 || n[0], n == 0 || n[1], g);
      wr(16'h3632, v);
      settle();
      `CHK({gain_switch_o, fixed_obj_o, rigid_en_o, torque_comp_o, load_est_o}, {v[10:4], v[1:0]})
      `CHK(inertia_upd_o, l == 0 ? 2'b00 : v[3:2])
      rd(16'h363A);
      `CHK(q, {5'h00, v[10:4], (l == 0 ? 2'b00 : v[3:2]), v[1:0]})
    end
    // Each warning but the two communication ones: raised, masked, then just below its trip point.
    thr = 16'($urandom % 1000);
    wr(16'h3637, thr);
    wr(16'h3638, 16'h0000);
    foreach (wb[k]) begin
      cond(wb[k], 1'b1);
      if (wb[k] == 6) repeat (FAN) @(posedge sys_clk_i);
      settle();
      `CHK({warn_any_o, warn_status_o[wb[k]]}, 2'b11)
      rd(16'h3639);
      `CHK(q, 16'h0001 << wb[k])
      wr(16'h3638, 16'h0001 << wb[k]);
      settle();
      `CHK(warn_status_o[wb[k]], 1'b0)
      cond(wb[k], 1'b0);
      wr(16'h3638, 16'h0000);
      settle();
      `CHK({warn_any_o, warn_status_o}, 17'h00000)
    end
    // Runs of communication errors, at the limit and one beyond it.
    for (int n = 3; n <= 4; n++) begin
      repeat (n) begin @(posedge sys_clk_i); {enc_comm_err_i, ext_comm_err_i} <= 2'b11; end
      @(posedge sys_clk_i);
      {enc_comm_err_i, ext_comm_err_i} <= 2'b00;
      settle();
      `CHK({warn_status_o[10], warn_status_o[4]}, n > 3 ? 2'b11 : 2'b00)
      @(posedge sys_clk_i);
      {enc_frame_ok_i, ext_frame_ok_i} <= 2'b11;
      @(posedge sys_clk_i);
      {enc_frame_ok_i, ext_frame_ok_i} <= 2'b00;
      settle();
      `CHK(warn_status_o, 16'h0000)
    end
    results();
  end
endmodule
`default_nettype wire
